// ===== tpc_consts.vh
// Purpose: shared constants for the trace port capture block
// Assumes: included by bare name, definitions only
// Notes:   register offsets are word indices on the plain register port
`ifndef TPC_CONSTS_VH
`define TPC_CONSTS_VH

// ****************************************
// register offsets
// ****************************************
`define TPC_REG_CTRL    4'h0
`define TPC_REG_STATUS  4'h1
`define TPC_REG_DATA    4'h2
`define TPC_REG_COUNT   4'h3
`define TPC_REG_ID      4'h4

// ****************************************
// control field positions and reset values
// ****************************************
`define TPC_CTRL_ENABLE   0
`define TPC_CTRL_STREAM   1
`define TPC_CTRL_SOURCE   2
`define TPC_CTRL_WIDTH_LO 4
`define TPC_CTRL_WIDTH_HI 6
`define TPC_CTRL_DELAY_LO 8
`define TPC_CTRL_DELAY_HI 10
`define TPC_WIDTH_RESET   3'h4
`define TPC_DELAY_RESET   3'h0

// ****************************************
// status field positions
// ****************************************
`define TPC_STAT_HALTED  0
`define TPC_STAT_VALID   1
`define TPC_STAT_WRAPPED 2
`define TPC_STAT_ONCHIP  3

// ****************************************
// timing
// ****************************************
`define TPC_CLK_MHZ       25
`define TPC_MIN_TRACE_MHZ 100
`define TPC_DELAY_MAX     7

`endif

// ===== tpc_nibble_packer.v
// Purpose: pack two edge samples of one trace clock period into a byte
// Assumes: sample strobes come from the capture front end, same clock
// Notes:   width below four masks the unused upper lines of each nibble
module tpc_nibble_packer (
	// clock and reset
	input  wire       clk,
	input  wire       rstn,
	input  wire       ce,
	// samples
	input  wire       riseStb,
	input  wire       fallStb,
	input  wire [3:0] sample,
	input  wire [2:0] width,
	// packed byte
	output reg        byteStb,
	output reg  [7:0] byteOut
);

	reg  [3:0] lowNib_reg;
	reg        haveLow_reg;
	wire [3:0] mask;

	// lines beyond the configured width read as zero
	assign mask = (width >= 3'h4) ? 4'hF : ((4'h1 << width[1:0]) - 4'h1);

	// rising edge nibble first, falling edge completes the byte
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lowNib_reg  <= 4'h0;
			haveLow_reg <= 1'b0;
			byteStb     <= 1'b0;
			byteOut     <= 8'h00;
		end else if (ce) begin
			byteStb <= 1'b0;
			if (riseStb) begin
				lowNib_reg  <= sample & mask;
				haveLow_reg <= 1'b1;
			end else if (fallStb && haveLow_reg) begin
				byteOut     <= {sample & mask, lowNib_reg};
				byteStb     <= 1'b1;
				haveLow_reg <= 1'b0;
			end
		end
	end

endmodule // tpc_nibble_packer

// ===== tpc_trace_capture.v
// Purpose: capture parallel double data rate trace into a ring or a stream
// Assumes: trace clock and data are slow enough for the sampling clock
// Notes:   registers on a plain port, read data one cycle after strobe
`include "tpc_consts.vh"

module tpc_trace_capture #(
	parameter DEPTH_LOG2 = 8,
	parameter ID_VALUE   = 32'h0000A5A5 // arbitrary identification value
) (
	// clock and reset
	input  wire        clk,
	input  wire        rstn,
	input  wire        ce,
	// trace pins from the target
	input  wire        traceClockIn,
	input  wire [3:0]  traceDataLines,
	input  wire        targetHalted,
	// on-chip buffer bytes fetched over the debug interface
	input  wire        debugByteValid,
	input  wire [7:0]  debugByte,
	// register port
	input  wire [3:0]  regAddr,
	input  wire [31:0] regWdata,
	input  wire        regWr,
	input  wire        regRd,
	output reg  [31:0] regRdata,
	// streaming output
	output reg         streamValid,
	output reg  [7:0]  streamByte,
	// debug interface fetch request
	output reg         debugFetchReq
);

	localparam DEPTH = 1 << DEPTH_LOG2;

	// ****************************************
	// input synchronisers
	// ****************************************
	reg        clkMeta_reg;
	reg        clkSync_reg;
	reg        clkPrev_reg;
	reg [3:0]  dataMeta_reg;
	reg [3:0]  dataSync_reg;
	reg        haltMeta_reg;
	reg        haltSync_reg;

	// two flops on every pin before use
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			clkMeta_reg  <= 1'b0;
			clkSync_reg  <= 1'b0;
			clkPrev_reg  <= 1'b0;
			dataMeta_reg <= 4'h0;
			dataSync_reg <= 4'h0;
			haltMeta_reg <= 1'b0;
			haltSync_reg <= 1'b0;
		end else if (ce) begin
			clkMeta_reg  <= traceClockIn;
			clkSync_reg  <= clkMeta_reg;
			clkPrev_reg  <= clkSync_reg;
			dataMeta_reg <= traceDataLines;
			dataSync_reg <= dataMeta_reg;
			haltMeta_reg <= targetHalted;
			haltSync_reg <= haltMeta_reg;
		end
	end

	// ****************************************
	// control register
	// ****************************************
	reg        enable_reg;
	reg        streamMode_reg;
	reg        onChipSrc_reg;
	reg [2:0]  portWidth_reg;
	reg [2:0]  sampleDelay_reg;
	wire       wrCtrl;
	wire [2:0] widthIn;

	assign wrCtrl  = regWr && (regAddr == `TPC_REG_CTRL);
	assign widthIn = regWdata[`TPC_CTRL_WIDTH_HI:`TPC_CTRL_WIDTH_LO];

	// width above four or zero is refused and keeps the old value
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			enable_reg      <= 1'b0;
			streamMode_reg  <= 1'b0;
			onChipSrc_reg   <= 1'b0;
			portWidth_reg   <= `TPC_WIDTH_RESET;
			sampleDelay_reg <= `TPC_DELAY_RESET;
		end else if (ce && wrCtrl) begin
			enable_reg      <= regWdata[`TPC_CTRL_ENABLE];
			onChipSrc_reg   <= regWdata[`TPC_CTRL_SOURCE];
			// streaming is forced off for the on-chip source
			streamMode_reg  <= regWdata[`TPC_CTRL_STREAM] & ~regWdata[`TPC_CTRL_SOURCE];
			if (widthIn != 3'h0 && widthIn <= 3'h4)
				portWidth_reg <= widthIn;
			sampleDelay_reg <= regWdata[`TPC_CTRL_DELAY_HI:`TPC_CTRL_DELAY_LO];
		end
	end

	// ****************************************
	// sample delay line
	// ****************************************
	// strobe and data pass through the same d cycles, so the sample is the data of the edge cycle;
	// a longer delay only makes each byte later, it adds no setup time
	reg [3:0] dataDly_reg [0:`TPC_DELAY_MAX];
	genvar g;
	generate
		for (g = 0; g < `TPC_DELAY_MAX; g = g + 1) begin : gDly
			always @(posedge clk or negedge rstn) begin
				if (!rstn)
					dataDly_reg[g+1] <= 4'h0;
				else if (ce)
					dataDly_reg[g+1] <= dataDly_reg[g];
			end
		end
	endgenerate

	always @* dataDly_reg[0] = dataSync_reg;

	reg  [`TPC_DELAY_MAX:0] riseDly_reg;
	reg  [`TPC_DELAY_MAX:0] fallDly_reg;
	wire                    riseNow;
	wire                    fallNow;

	// edges of the sampled trace clock
	assign riseNow = clkSync_reg & ~clkPrev_reg;
	assign fallNow = ~clkSync_reg & clkPrev_reg;

	// edge strobes are delayed alongside the data so they stay paired
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			riseDly_reg <= {(`TPC_DELAY_MAX+1){1'b0}};
			fallDly_reg <= {(`TPC_DELAY_MAX+1){1'b0}};
		end else if (ce) begin
			riseDly_reg <= {riseDly_reg[`TPC_DELAY_MAX-1:0], riseNow};
			fallDly_reg <= {fallDly_reg[`TPC_DELAY_MAX-1:0], fallNow};
		end
	end

	wire [3:0] sample;
	wire       riseStb;
	wire       fallStb;
	assign riseStb = riseNow & (sampleDelay_reg == 3'h0) |
		(sampleDelay_reg != 3'h0) & riseDly_reg[sampleDelay_reg - 3'h1];
	assign fallStb = fallNow & (sampleDelay_reg == 3'h0) |
		(sampleDelay_reg != 3'h0) & fallDly_reg[sampleDelay_reg - 3'h1];
	// strobe at delay d reads data delayed by the same d cycles, sampled in the cycle of the edge
	assign sample  = dataDly_reg[sampleDelay_reg];

	// ****************************************
	// byte assembly
	// ****************************************
	wire       pinByteStb;
	wire [7:0] pinByte;

	tpc_nibble_packer uPacker (
		.clk     (clk),
		.rstn    (rstn),
		.ce      (ce),
		.riseStb (riseStb & enable_reg & ~onChipSrc_reg),
		.fallStb (fallStb & enable_reg & ~onChipSrc_reg),
		.sample  (sample),
		.width   (portWidth_reg),
		.byteStb (pinByteStb),
		.byteOut (pinByte)
	);

	// source mux: pins or bytes read back over the debug interface
	wire       capStb;
	wire [7:0] capByte;
	assign capStb  = onChipSrc_reg ? (debugByteValid & enable_reg) : pinByteStb;
	assign capByte = onChipSrc_reg ? debugByte : pinByte;

	// ****************************************
	// ring store and stream path
	// ****************************************
	reg [7:0]            ring_reg [0:DEPTH-1];
	reg [DEPTH_LOG2-1:0] wrPtr_reg;
	reg [DEPTH_LOG2-1:0] rdPtr_reg;
	reg [DEPTH_LOG2:0]   fill_reg;
	reg                  wrapped_reg;
	wire                 bufRead;
	wire                 canRead;

	assign canRead = haltSync_reg && (fill_reg != {(DEPTH_LOG2+1){1'b0}});
	assign bufRead = regRd && (regAddr == `TPC_REG_DATA) && canRead && !streamMode_reg;

	// store never blocks: once full the oldest byte goes
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr_reg   <= {DEPTH_LOG2{1'b0}};
			rdPtr_reg   <= {DEPTH_LOG2{1'b0}};
			fill_reg    <= {(DEPTH_LOG2+1){1'b0}};
			wrapped_reg <= 1'b0;
		end else if (ce) begin
			// clear first so an overwrite in the same cycle still sets the flag
			if (wrCtrl)
				wrapped_reg <= 1'b0;
			if (capStb && !streamMode_reg) begin
				wrPtr_reg <= wrPtr_reg + 1'b1;
				if (fill_reg == DEPTH[DEPTH_LOG2:0]) begin
					rdPtr_reg   <= rdPtr_reg + 1'b1;
					wrapped_reg <= 1'b1;
				end else
					fill_reg <= fill_reg + 1'b1;
			end else if (bufRead) begin
				rdPtr_reg <= rdPtr_reg + 1'b1;
				fill_reg  <= fill_reg - 1'b1;
			end
		end
	end

	// store writes, no reset on the array
	always @(posedge clk) begin
		if (ce && capStb && !streamMode_reg)
			ring_reg[wrPtr_reg] <= capByte;
	end

	// stream bytes leave as they arrive, target keeps running
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			streamValid <= 1'b0;
			streamByte  <= 8'h00;
		end else if (ce) begin
			streamValid <= capStb & streamMode_reg;
			if (capStb && streamMode_reg)
				streamByte <= capByte;
		end
	end

	// on-chip source: ask for the next byte over the debug interface
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			debugFetchReq <= 1'b0;
		else if (ce)
			debugFetchReq <= enable_reg & onChipSrc_reg & ~debugByteValid;
	end

	// ****************************************
	// register read back
	// ****************************************
	// fast trace clock support rests on the sampler rate; a byte per period
	// is sustained only while the trace clock is under half of clk
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			regRdata <= 32'h00000000;
		else if (ce) begin
			regRdata <= 32'h00000000;
			if (regRd) begin
				case (regAddr)
					`TPC_REG_CTRL:
						regRdata <= {21'h00000, sampleDelay_reg, 1'b0, portWidth_reg,
							1'b0, onChipSrc_reg, streamMode_reg, enable_reg};
					`TPC_REG_STATUS:
						regRdata <= {28'h0000000, onChipSrc_reg, wrapped_reg,
							canRead, haltSync_reg};
					`TPC_REG_DATA:
						regRdata <= bufRead ? {24'h000000, ring_reg[rdPtr_reg]} : 32'h00000000;
					`TPC_REG_COUNT:
						regRdata <= {{(31-DEPTH_LOG2){1'b0}}, fill_reg};
					`TPC_REG_ID:
						regRdata <= ID_VALUE;
					default:
						regRdata <= 32'h00000000;
				endcase
			end
		end
	end

endmodule // tpc_trace_capture

// ===== tpc_trace_capture_properties.sv
// Purpose: concurrent checks on the trace capture ports
// Assumes: ce held high, control writes made while the trace clock is idle
// Notes:   shadows control fields seen on register writes
module tpc_trace_capture_properties #(
	parameter ID_VALUE = 32'h0000A5A5 // arbitrary identification value
) (
	// clock and reset
	input wire        clk,
	input wire        rstn,
	input wire        ce,
	// trace side
	input wire        traceClockIn,
	input wire        targetHalted,
	// register port
	input wire [3:0]  regAddr,
	input wire [31:0] regWdata,
	input wire        regWr,
	input wire        regRd,
	input wire [31:0] regRdata,
	// outputs
	input wire        streamValid,
	input wire        debugFetchReq
);
	// ****************************************
	// control shadow and checks
	// ****************************************
	logic [2:0] widthReg;
	logic       onchipReg;
	logic       streamOn;

	// shadow follows accepted writes only, so ignored widths stay out
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			widthReg <= 3'h4;
			onchipReg <= 1'b0;
			streamOn <= 1'b0;
		end else if (ce && regWr && regAddr == 4'h0) begin
			if (regWdata[6:4] >= 3'h1 && regWdata[6:4] <= 3'h4)
				widthReg <= regWdata[6:4];
			onchipReg <= regWdata[2];
			streamOn <= regWdata[0] & regWdata[1] & ~regWdata[2];
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sequence s_running;
		!targetHalted [*4];
	endsequence
	sequence s_fallInStream;
		streamOn && $fell(traceClockIn);
	endsequence

	chk_read_window: assert property (!$past(regRd) |-> regRdata == 32'h0)
		else $error("read data outside its cycle");
	chk_width_shadow: assert property (
		regRd && regAddr == 4'h0 |=> regRdata[6:4] == widthReg)
		else $error("port width field wrong");
	chk_halt_gate: assert property (
		s_running ##0 (regRd && regAddr == 4'h2) |=> regRdata == 32'h0)
		else $error("buffer data given while running");
	chk_stream_follows: assert property (
		s_fallInStream |-> ##[3:14] streamValid)
		else $error("streamed byte missing");
	chk_byte_spacing: assert property (
		streamValid |=> !streamValid [*5])
		else $error("more than one byte per period");
	chk_onchip_nostream: assert property (onchipReg |-> !streamValid)
		else $error("stream while on-chip source");
	chk_fetch_idle: assert property (
		!onchipReg && !$past(onchipReg) |-> !debugFetchReq)
		else $error("fetch while pin source");
	chk_id_value: assert property (regRd && regAddr == 4'h4 |=> regRdata == ID_VALUE)
		else $error("identification value wrong");
endmodule // tpc_trace_capture_properties

bind tpc_trace_capture tpc_trace_capture_properties #(.ID_VALUE(ID_VALUE)) chk_u (
	.clk(clk), .rstn(rstn), .ce(ce), .traceClockIn(traceClockIn),
	.targetHalted(targetHalted), .regAddr(regAddr), .regWdata(regWdata),
	.regWr(regWr), .regRd(regRd), .regRdata(regRdata),
	.streamValid(streamValid), .debugFetchReq(debugFetchReq));

// ===== tpc_trace_target.sv
// Purpose: behavioural trace unit and on-chip buffer of the target
// Assumes: bench calls send and idle, clock stands low between frames
// Notes:   zeroSetup moves data onto the clock edge itself
module tpc_trace_target #(
	parameter int ONCHIP_BYTES = 1024
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// behaviour
	input  wire logic zeroSetup,
	// trace pins
	output logic       traceClockIn,
	output logic [3:0] traceDataLines,
	// on-chip buffer over the debug interface
	input  wire logic  debugFetchReq,
	output logic       debugByteValid,
	output logic [7:0] debugByte
);
	// ****************************************
	// pin and buffer model
	// ****************************************
	int   sent;
	logic give;

	initial begin
		traceClockIn = 1'b0;
		traceDataLines = 4'h5;
	end

	// one clock edge with its nibble, data leads by half a phase unless zeroSetup puts it on the edge
	task automatic edgeOut(input logic [3:0] n, input logic lvl);
		#80;
		if (!zeroSetup) traceDataLines = n;
		#80;
		traceClockIn = lvl;
		if (zeroSetup) traceDataLines = n;
	endtask

	// a byte spans one trace period, both edges
	task automatic send(input logic [7:0] b);
		edgeOut(b[3:0], 1'b1);
		edgeOut(b[7:4], 1'b0);
	endtask

	// lines are not held after the frame
	task automatic idle();
		#80;
		traceDataLines = ~traceDataLines;
	endtask

	// buffer is finite, so fetches stop answering once drained
	assign give = debugFetchReq && !debugByteValid && sent < ONCHIP_BYTES;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			debugByteValid <= 1'b0;
			debugByte <= 8'h00;
			sent <= 0;
		end else begin
			debugByteValid <= give;
			debugByte <= give ? 8'(sent) : ~debugByte;
			sent <= sent + (give ? 1 : 0);
		end
	end
endmodule // tpc_trace_target

// ===== tb_tpc_trace_capture.sv
// Purpose: self-checking bench for the trace capture block
// Assumes: ce tied high, target model drives the pins
// Notes:   ring cut to eight entries so ten bytes wrap
module tb_tpc_trace_capture;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// wiring, tasks and sequence
	// ****************************************
	logic clk, rstn, halted, wr, rd, zs;
	logic [3:0] addr;
	logic [31:0] wdata, seed, d;
	wire logic trace_clock_in, dbv, dfr, sv;
	wire logic [3:0] tdl;
	wire logic [7:0] dbb, sb;
	wire logic [31:0] rdata;
	int mismatches, n_tests, exw;
	logic [7:0] q[$], ex[$];

	tpc_trace_capture #(.DEPTH_LOG2(3)) dut_u (.clk(clk), .rstn(rstn), .ce(1'b1),
		.traceClockIn(trace_clock_in), .traceDataLines(tdl), .targetHalted(halted),
		.debugByteValid(dbv), .debugByte(dbb), .regAddr(addr), .regWdata(wdata),
		.regWr(wr), .regRd(rd), .regRdata(rdata), .streamValid(sv),
		.streamByte(sb), .debugFetchReq(dfr));
	tpc_trace_target tgt_u (.clk(clk), .rstn(rstn), .zeroSetup(zs),
		.traceClockIn(trace_clock_in), .traceDataLines(tdl), .debugFetchReq(dfr),
		.debugByteValid(dbv), .debugByte(dbb));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// control word from enable/stream/source bits, width, delay
	function automatic logic [31:0] ctl(input int f, input int w, input int dl);
		return 32'(f) | (32'(w) << 4) | (32'(dl) << 8);
	endfunction
	task automatic wreg(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		cmp(rdata, e);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// random bytes out of the target, remembered in order
	task automatic frames(input int n, input bit strm);
		for (int i = 0; i < n; i++) begin
			d = rnd();
			ex.push_back(d[7:0]);
			tgt_u.send(d[7:0]);
		end
		tgt_u.idle();
		// only the stream path fills q; a bound that runs out is a mismatch
		if (strm) begin
			for (int i = 0; i < 400 && q.size() < ex.size(); i++) @(posedge clk);
			if (q.size() < ex.size()) cmp(32'(q.size()), 32'(ex.size()));
		end
	endtask

	always @(posedge clk) if (sv === 1'b1) q.push_back(sb);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		{rstn, halted, wr, rd, zs, addr, wdata, mismatches, n_tests} = '0;
		seed = 32'h7edd7375;
		exw = 4;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rchk(4'h0, 32'h40);
		rchk(4'hF, 32'h0);
		// only widths one to four are taken
		for (int w = 0; w < 8; w++) begin
			wreg(4'h0, ctl(0, w, 0));
			if (w >= 1 && w <= 4) exw = w;
			rchk(4'h0, ctl(0, exw, 0));
		end
		// buffered: ten bytes into eight places, read only when halted
		wreg(4'h0, ctl(1, 4, 0));
		#7;
		frames(10, 1'b0);
		repeat (12) @(posedge clk);
		rchk(4'h2, 32'h0);
		halted <= 1'b1;
		repeat (4) @(posedge clk);
		rchk(4'h3, 32'h8);
		rchk(4'h1, 32'h7);
		for (int i = 2; i < 10; i++) rchk(4'h2, 32'(ex[i]));
		rchk(4'h3, 32'h0);
		halted <= 1'b0;
		// streaming, then data on the edge with a sampling delay
		for (int p = 0; p < 2; p++) begin
			zs = p[0];
			wreg(4'h0, ctl(3, 4, 2 * p));
			q.delete();
			ex.delete();
			frames(6, 1'b1);
			if (q.size() != 6) cmp(32'(q.size()), 32'h6);
			foreach (ex[i]) cmp(32'(q[i]), 32'(ex[i]));
		end
		// on-chip source drops streaming and fetches over debug
		wreg(4'h0, ctl(7, 4, 0));
		rchk(4'h0, ctl(5, 4, 0));
		rchk(4'h1, 32'h8);
		for (int i = 0; i < 50 && dfr !== 1'b1; i++) @(posedge clk);
		cmp(32'(dfr), 32'h1);
		results();
	end
endmodule // tb_tpc_trace_capture
